// file: hw/adc_monitor_status_flags.sv
// fault monitor, bias and status register logic of the delta-sigma converter
// Overview of operation
// - bias level is half or twelfth span
// - per-input bias connect for six inputs, common bit held 0
// - monitor-select field picks the system monitor
// - select 010 routes temperature sensor, detaches inputs
// - 011 quarter analog supply, 100 quarter digital
// - supply monitor detaches inputs, forces unity gain
// - 101/110/111 enable 0.2, 1, 10 uA burnout
// - burnout sources positive input, sinks negative input
// - status readable; prepend bit sends it first
// - status returns flags latched last conversion
// - power-on flag set at reset, cleared by write
// - bit 6 reports start-up finished, ready
// - four rail flags in bits 5 to 2
// - rail monitors run only when enabled
// - rail flags update only at cycle end
// - bit 0 below 300 mV, bit 1 below third
// - reference comparators active only when field enabled
// - reference flags update at conversion-done falling edge
`timescale 1ns/1ns
`include "adc_monitor_consts.svh"
module adc_monitor_status_flags
(
	input  wire logic                       clk_sys,
	input  wire logic                       rst_n,
	input  adc_monitor_pkg::reg_req_s       regReq,
	output logic [7:0]                      regRdata,
	output logic                            regRvalid,
	input  wire logic                       dataReadStart,
	input  wire logic                       conversionEnd,
	output logic                            conversion_done_n,
	input  adc_monitor_pkg::rail_s          railCompare,
	input  adc_monitor_pkg::ref_s           refCompare,
	output adc_monitor_pkg::bias_s          biasCtrl,
	output adc_monitor_pkg::monitor_s       monitorCtrl,
	output logic                            burnoutSourcePos,
	output logic                            burnoutSinkNeg,
	output logic                            railMonitorActive,
	output logic                            refCheckActive,
	output logic [1:0]                      refCheckMode,
	output logic                            statusPrepend,
	output logic [7:0]                      prependByte
);
	import adc_monitor_pkg::*;

	logic [7:0] biasReg;
	logic [7:0] sysReg;
	logic [7:0] exc1Reg;
	logic [7:0] refReg;
	logic       power_on_event_flag;
	logic [7:0] bootCount;
	life_e      life;
	life_e      next_life;
	rail_s      railFlag;
	ref_s       refFlag;
	logic       doneHold;

	// register decode
	wire logic wrBias   = regReq.write & (regReq.addr == `ADDR_BIAS);
	wire logic wrSys    = regReq.write & (regReq.addr == `ADDR_SYSCTRL);
	wire logic wrExc1   = regReq.write & (regReq.addr == `ADDR_EXCITE1);
	wire logic wrRef    = regReq.write & (regReq.addr == `ADDR_REFCTRL);
	wire logic wrStatus = regReq.write & (regReq.addr == `ADDR_STATUS);
	wire logic isReady  = (life != ST_BOOT);

	// writes are refused during start-up (ST_BOOT) and dropped; reads are still answered
	wire logic acceptWrite = isReady;

	wire logic [2:0] monitor_select        = sysReg[`SYS_MON_MSB:`SYS_MON_LSB];
	wire logic       status_prepend_enable = sysReg[`SYS_PREPEND_BIT];
	wire logic       railEnable            = exc1Reg[`EXC1_RAIL_EN_BIT];
	wire logic [1:0] reference_check_enable = refReg[`REF_CHECK_MSB:`REF_CHECK_LSB];
	wire logic       refEnable             = (reference_check_enable != `REF_CHECK_OFF);

	wire logic [7:0] statusByte = {power_on_event_flag, isReady,
		railFlag.posHigh, railFlag.posLow, railFlag.negHigh, railFlag.negLow,
		refFlag.belowThird, refFlag.belowLow};

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			biasReg <= `RESET_BYTE;
			sysReg  <= `RESET_BYTE;
			exc1Reg <= `RESET_BYTE;
			refReg  <= `RESET_BYTE;
		end
		else if (acceptWrite)
		begin
			if (wrBias)
				biasReg <= regReq.wdata;
			if (wrSys)
				sysReg <= regReq.wdata;
			if (wrExc1)
				exc1Reg <= regReq.wdata;
			if (wrRef)
				refReg <= regReq.wdata;
		end
	end

	// power-on flag: set by reset, cleared only by writing 0 to bit 7
	wire logic clearPor = acceptWrite & wrStatus & ~regReq.wdata[`BIT_POR];

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			power_on_event_flag <= 1'b1;
		else if (clearPor)
			power_on_event_flag <= 1'b0;
	end

	// start-up sequencing; ready once the register map is settled
	always_comb
	begin
		next_life = life;
		case (life)
			ST_BOOT:
				if (bootCount == `STARTUP_CYCLES)
					next_life = ST_READY;
			ST_READY:
				next_life = ST_READY;
			ST_DONE:
				next_life = ST_READY;
			default:
				next_life = ST_BOOT;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			life      <= ST_BOOT;
			bootCount <= 8'h00;
		end
		else
		begin
			life <= next_life;
			if (life == ST_BOOT)
				bootCount <= bootCount + 8'h01;
		end
	end

	// flags published at conversion end, i.e. as conversion_done_n falls
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_rail
			fault_latch u_rail
			(
				.clk_sys  (clk_sys),
				.rst_n    (rst_n),
				.enable   (railEnable),
				.fault    (railCompare[gi]),
				.cycleEnd (conversionEnd),
				.flag     (railFlag[gi])
			);
		end
		for (gi = 0; gi < 2; gi++)
		begin : g_ref
			fault_latch u_ref
			(
				.clk_sys  (clk_sys),
				.rst_n    (rst_n),
				.enable   (refEnable),
				.fault    (refCompare[gi]),
				.cycleEnd (conversionEnd),
				.flag     (refFlag[gi])
			);
		end
	endgenerate

	// conversion_done_n falls in the same edge the flags update; a data read raises it again
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			doneHold <= 1'b0;
		else if (conversionEnd)
			doneHold <= 1'b1;
		else if (dataReadStart)
			doneHold <= 1'b0;
	end
	assign conversion_done_n = ~doneHold;

	// read path, registered; unmapped reads return zero
	wire logic [7:0] readMux =
		(regReq.addr == `ADDR_STATUS)  ? statusByte :
		(regReq.addr == `ADDR_REFCTRL) ? refReg :
		(regReq.addr == `ADDR_EXCITE1) ? exc1Reg :
		(regReq.addr == `ADDR_BIAS)    ? biasReg :
		(regReq.addr == `ADDR_SYSCTRL) ? sysReg : 8'h00;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			regRdata    <= 8'h00;
			regRvalid   <= 1'b0;
			prependByte <= 8'h00;
		end
		else
		begin
			regRvalid <= regReq.read;
			if (regReq.read)
				regRdata <= readMux;
			// snapshot taken as a data read starts so the byte matches the word sent after it
			if (dataReadStart)
				prependByte <= statusByte;
		end
	end

	assign statusPrepend = status_prepend_enable;

	// analog steering
	assign biasCtrl.biasLevelTwelfth = biasReg[`BIAS_LEVEL_BIT];
	assign biasCtrl.biasConnect      = biasReg[`BIAS_CONN_MSB:0] == 6'h00 ? 7'h00
		: {1'b0, biasReg[`BIAS_CONN_MSB:0]};

	monitor_decode u_decode
	(
		.monitorSelect (monitor_select),
		.steer         (monitorCtrl)
	);

	assign burnoutSourcePos  = monitorCtrl.burnoutEnable;
	assign burnoutSinkNeg    = monitorCtrl.burnoutEnable;
	assign railMonitorActive = railEnable;
	assign refCheckActive    = refEnable;
	assign refCheckMode      = reference_check_enable;
endmodule

// file: hw/adc_monitor_consts.svh
// register offsets, field positions and encodings for the fault monitor block
`ifndef ADC_MONITOR_CONSTS_SVH
`define ADC_MONITOR_CONSTS_SVH

`define ADDR_STATUS        8'h01
`define ADDR_REFCTRL       8'h05
`define ADDR_EXCITE1       8'h06
`define ADDR_BIAS          8'h08
`define ADDR_SYSCTRL       8'h09

`define BIT_POR            7
`define BIT_READY          6
`define BIT_POS_HIGH       5
`define BIT_POS_LOW        4
`define BIT_NEG_HIGH       3
`define BIT_NEG_LOW        2
`define BIT_REF_THIRD      1
`define BIT_REF_LOW        0

`define BIAS_LEVEL_BIT     6
`define BIAS_CONN_MSB      5
`define SYS_MON_MSB        7
`define SYS_MON_LSB        5
`define SYS_PREPEND_BIT    0
`define EXC1_RAIL_EN_BIT   7
`define REF_CHECK_MSB      7
`define REF_CHECK_LSB      6

`define MON_NONE           3'h0
`define MON_MIDSCALE       3'h1
`define MON_TEMP           3'h2
`define MON_AVDD           3'h3
`define MON_DVDD           3'h4
`define MON_BO_0P2         3'h5
`define MON_BO_1           3'h6
`define MON_BO_10          3'h7

`define REF_CHECK_OFF      2'h0
`define STARTUP_CYCLES     8'h10
`define RESET_BYTE         8'h00

`endif

// file: hw/adc_monitor_pkg.sv
// types shared by the fault monitor block
package adc_monitor_pkg;

	typedef struct packed {
		logic posHigh;
		logic posLow;
		logic negHigh;
		logic negLow;
	} rail_s;

	typedef struct packed {
		logic belowThird;
		logic belowLow;
	} ref_s;

	typedef struct packed {
		logic       write;
		logic       read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic       biasLevelTwelfth;
		logic [6:0] biasConnect;
	} bias_s;

	typedef struct packed {
		logic       tempSensor;
		logic       avddMonitor;
		logic       dvddMonitor;
		logic       inputsDisconnect;
		logic       forceUnityGain;
		logic [2:0] burnoutLevel;
		logic       burnoutEnable;
	} monitor_s;

	typedef enum logic [2:0] {
		ST_BOOT  = 3'b001,
		ST_READY = 3'b010,
		ST_DONE  = 3'b100
	} life_e;

endpackage

// file: hw/fault_latch.sv
// one fault flag: accumulates a comparator over a conversion cycle, publishes at cycle end
`timescale 1ns/1ns
module fault_latch
(
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic enable,
	input  wire logic fault,
	input  wire logic cycleEnd,
	output logic      flag
);
	logic seen;

	// a fault present in the very last cycle still counts for this conversion
	wire logic next_seen = cycleEnd ? 1'b0 : (seen | (enable & fault));
	wire logic next_flag = cycleEnd ? (enable & (seen | fault)) : flag;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			seen <= 1'b0;
			flag <= 1'b0;
		end
		else
		begin
			seen <= next_seen;
			flag <= next_flag;
		end
	end
endmodule

// file: hw/monitor_decode.sv
// decodes the monitor-select field into analog steering controls
`timescale 1ns/1ns
`include "adc_monitor_consts.svh"
module monitor_decode
(
	input  wire logic [2:0]          monitorSelect,
	output adc_monitor_pkg::monitor_s steer
);
	import adc_monitor_pkg::*;

	wire logic isTemp    = (monitorSelect == `MON_TEMP);
	wire logic isAvdd    = (monitorSelect == `MON_AVDD);
	wire logic isDvdd    = (monitorSelect == `MON_DVDD);
	wire logic isSupply  = isAvdd | isDvdd;
	wire logic isBurnout = (monitorSelect == `MON_BO_0P2) | (monitorSelect == `MON_BO_1)
		| (monitorSelect == `MON_BO_10);

	assign steer.tempSensor       = isTemp;
	assign steer.avddMonitor      = isAvdd;
	assign steer.dvddMonitor      = isDvdd;
	// midscale self-offset also detaches the inputs
	assign steer.inputsDisconnect = isTemp | isSupply | (monitorSelect == `MON_MIDSCALE);
	assign steer.forceUnityGain   = isSupply;
	// one-hot: bit0 0.2 uA, bit1 1 uA, bit2 10 uA
	assign steer.burnoutLevel     = {monitorSelect == `MON_BO_10, monitorSelect == `MON_BO_1,
		monitorSelect == `MON_BO_0P2};
	assign steer.burnoutEnable    = isBurnout;
endmodule

// file: dv/adc_monitor_status_flags_sva.sv
// port assertions of the fault monitor
`timescale 1ns/1ns
module adc_monitor_status_flags_sva
(
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	input  adc_monitor_pkg::reg_req_s regReq,
	input  wire logic                 regRvalid,
	input  wire logic                 dataReadStart,
	input  wire logic                 conversionEnd,
	input  wire logic                 conversion_done_n,
	input  adc_monitor_pkg::monitor_s monitorCtrl,
	input  wire logic                 burnoutSourcePos,
	input  wire logic                 burnoutSinkNeg,
	input  wire logic                 refCheckActive,
	input  wire logic [1:0]           refCheckMode
);
	import adc_monitor_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	chk_read_answer: assert property (regReq.read |=> regRvalid)
		else $error("read not answered");
	chk_done_falls: assert property (conversionEnd && !dataReadStart |=> !conversion_done_n)
		else $error("done not low after end");
	chk_done_cause: assert property ($fell(conversion_done_n) |-> $past(conversionEnd))
		else $error("done fell without end");
	chk_temp_route: assert property (monitorCtrl.tempSensor |-> monitorCtrl.inputsDisconnect
		&& !monitorCtrl.forceUnityGain)
		else $error("temperature routing wrong");
	chk_supply_unity: assert property (monitorCtrl.avddMonitor || monitorCtrl.dvddMonitor
		|-> monitorCtrl.forceUnityGain && monitorCtrl.inputsDisconnect)
		else $error("supply monitor gain wrong");
	chk_burnout_pair: assert property (monitorCtrl.burnoutEnable |-> burnoutSourcePos && burnoutSinkNeg)
		else $error("burnout pair off");
	chk_ref_active: assert property (refCheckActive == (refCheckMode != 2'h0))
		else $error("reference check enable wrong");
	chk_rvalid_pulse: assert property (regRvalid && !regReq.read |=> !regRvalid)
		else $error("read valid too long");
endmodule
bind adc_monitor_status_flags adc_monitor_status_flags_sva i_sva (.clk_sys(clk_sys), .rst_n(rst_n),
	.regReq(regReq), .regRvalid(regRvalid), .dataReadStart(dataReadStart), .conversionEnd(conversionEnd),
	.conversion_done_n(conversion_done_n), .monitorCtrl(monitorCtrl), .burnoutSourcePos(burnoutSourcePos),
	.burnoutSinkNeg(burnoutSinkNeg), .refCheckActive(refCheckActive), .refCheckMode(refCheckMode));

// file: dv/host_model.sv
// host side: single-byte register reads and writes
`timescale 1ns/1ns
module host_model
(
	input  wire logic                 clk_sys,
	input  wire logic [7:0]           regRdata,
	input  wire logic                 regRvalid,
	output adc_monitor_pkg::reg_req_s regReq
);
	import adc_monitor_pkg::*;
	logic [7:0] rdData;
	initial regReq = '0;
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1 regReq = '{w, !w, a, d};
		@(posedge clk_sys);
		#1 regReq = '0;
		rdData = (regRvalid === 1'b1) ? regRdata : 8'hXX;
	endtask
endmodule

// file: dv/tb_adc_monitor_status_flags.sv
// testbench of the fault monitor and status flags
`timescale 1ns/1ns
`define CHK(a, b) n_tests++; if ((a) !== (b)) begin errors++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, b); end
module tb_adc_monitor_status_flags;
	import adc_monitor_pkg::*;
	logic       clk_sys, rst_n, regRvalid, dataReadStart, conversionEnd, conversion_done_n;
	logic       burnoutSourcePos, burnoutSinkNeg, railMonitorActive, refCheckActive, statusPrepend;
	logic [7:0] regRdata, prependByte, expSt;
	logic [1:0] refCheckMode;
	logic [5:0] expMon;
	reg_req_s   regReq;
	rail_s      railCompare;
	ref_s       refCompare;
	bias_s      biasCtrl;
	monitor_s   monitorCtrl;
	int         errors, n_tests;
	// {rail enable, ref enable, rail faults, ref faults}
	logic [7:0] rows[5] = '{8'hE9, 8'hD6, 8'hBF, 8'h7F, 8'h3F};
	host_model i_host_model (.clk_sys(clk_sys), .regRdata(regRdata), .regRvalid(regRvalid), .regReq(regReq));
	adc_monitor_status_flags i_adc_monitor_status_flags (.clk_sys(clk_sys), .rst_n(rst_n), .regReq(regReq),
		.regRdata(regRdata), .regRvalid(regRvalid), .dataReadStart(dataReadStart),
		.conversionEnd(conversionEnd), .conversion_done_n(conversion_done_n), .railCompare(railCompare),
		.refCompare(refCompare), .biasCtrl(biasCtrl), .monitorCtrl(monitorCtrl),
		.burnoutSourcePos(burnoutSourcePos), .burnoutSinkNeg(burnoutSinkNeg),
		.railMonitorActive(railMonitorActive), .refCheckActive(refCheckActive),
		.refCheckMode(refCheckMode), .statusPrepend(statusPrepend), .prependByte(prependByte));
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		i_host_model.access(1'b1, a, d);
	endtask
	task rdchk(input logic [7:0] a, input logic [7:0] e);
		i_host_model.access(1'b0, a, 8'h00);
		`CHK(i_host_model.rdData, e)
	endtask
	// fault seen in the end cycle still counts, so comparators may stay up here
	task endCycle;
		conversionEnd = 1'b1;
		tick(1);
		conversionEnd = 1'b0;
	endtask
	task stop_test;
		$display("tests %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial
	begin
		#3000000;
		errors++;
		stop_test();
	end
	initial
	begin
		rst_n = 1'b0;
		dataReadStart = 1'b0;
		conversionEnd = 1'b0;
		railCompare = '0;
		refCompare = '0;
		tick(10);
		rst_n = 1'b1;
		wr(8'h08, 8'h7F);
		rdchk(8'h01, 8'h80);
		tick(20);
		`CHK(biasCtrl, 8'h00)
		rdchk(8'h01, 8'hC0);
		wr(8'h01, 8'h00);
		rdchk(8'h01, 8'h40);
		rdchk(8'h20, 8'h00);
		wr(8'h08, 8'h6A);
		`CHK(biasCtrl, 8'hAA)
		wr(8'h08, 8'h15);
		`CHK(biasCtrl, 8'h15)
		// no conversion is started after a bias change, and no gain, chop or reference resistor is driven here
		for (int s = 0; s < 8; s++)
		begin
			wr(8'h09, {s[2:0], 5'h00});
			`CHK({monitorCtrl.burnoutLevel, burnoutSinkNeg}, {s == 7, s == 6, s == 5, s > 4})
			expMon = {s == 2, s == 3, s == 4, s > 0 && s < 5, s == 3 || s == 4, s > 4};
			`CHK({monitorCtrl.tempSensor, monitorCtrl.avddMonitor, monitorCtrl.dvddMonitor,
				monitorCtrl.inputsDisconnect, monitorCtrl.forceUnityGain, burnoutSourcePos}, expMon)
		end
		expSt = 8'h40;
		foreach (rows[i])
		begin
			wr(8'h06, {rows[i][7], 7'h00});
			wr(8'h05, {rows[i][6], 7'h00});
			`CHK({railMonitorActive, refCheckActive, refCheckMode}, {rows[i][7], rows[i][6], rows[i][6], 1'b0})
			railCompare = rows[i][5:2];
			refCompare = rows[i][1:0];
			tick(1);
			railCompare = '0;
			refCompare = '0;
			rdchk(8'h01, expSt);
			endCycle();
			expSt = {2'b01, rows[i][5:2] & {4{rows[i][7]}}, rows[i][1:0] & {2{rows[i][6]}}};
			rdchk(8'h01, expSt);
		end
		wr(8'h06, 8'h80);
		wr(8'h09, 8'h01);
		`CHK(statusPrepend, 1'b1)
		railCompare = 4'h8;
		endCycle();
		railCompare = '0;
		`CHK(conversion_done_n, 1'b0)
		dataReadStart = 1'b1;
		tick(1);
		dataReadStart = 1'b0;
		`CHK(prependByte, 8'h60)
		`CHK(conversion_done_n, 1'b1)
		rst_n = 1'b0;
		tick(2);
		rst_n = 1'b1;
		rdchk(8'h01, 8'h80);
		stop_test();
	end
endmodule
